// >>> dsoc_cfg.svh
// Object indices, field positions, reset values and accepted sets of the stop option control
`ifndef DSOC_CFG_SVH
`define DSOC_CFG_SVH

`define DSOC_IDX_QSO 16'h605a
`define DSOC_IDX_SDO 16'h605b
`define DSOC_IDX_DOO 16'h605c
`define DSOC_IDX_HLO 16'h605d
`define DSOC_IDX_MODE 16'h6060
`define DSOC_IDX_MODE_DISP 16'h6061
`define DSOC_IDX_STATUS 16'h6041

`define DSOC_RST_QSO 16'h0002
`define DSOC_RST_SDO 16'h0001
`define DSOC_RST_DOO 16'h0001
`define DSOC_RST_HLO 16'h0001
`define DSOC_RST_MODE 8'h00

`define DSOC_ACC_QSO 16'h00ef
`define DSOC_ACC_SDO 16'h0003
`define DSOC_ACC_DOO 16'h0003
`define DSOC_ACC_HLO 16'h000e
`define DSOC_ACC_MODE 16'h034b

`define DSOC_SW_RTSO 0
`define DSOC_SW_SO 1
`define DSOC_SW_OE 2
`define DSOC_SW_FAULT 3
`define DSOC_SW_VOLT 4
`define DSOC_SW_QS 5
`define DSOC_SW_SOD 6
`define DSOC_SW_INFO 7
`define DSOC_SW_REMOTE 9
`define DSOC_SW_ILIM 11

`define DSOC_CW_FRESET 7
`define DSOC_CW_HALT 8

`define DSOC_MODE_NONE 8'h00
`define DSOC_MODE_PP 8'h01
`define DSOC_MODE_PV 8'h03
`define DSOC_MODE_HM 8'h06
`define DSOC_MODE_CSP 8'h08
`define DSOC_MODE_CSV 8'h09

`endif

// >>> dsoc_pkg.sv
// Types shared by the stop option control
package dsoc_pkg;

  typedef enum logic [3:0] {
    DSM_SOD, DSM_READY, DSM_SWON, DSM_OPEN, DSM_STOP_SHUT, DSM_STOP_DIS, DSM_QSA, DSM_FAULT
  } dsoc_state_e;

  typedef enum logic [1:0] {DEC_NONE, DEC_PROFILE, DEC_QUICK, DEC_IMMED} dsoc_decel_e;

  typedef enum logic [2:0] {
    MODE_NONE, MODE_PP, MODE_PV, MODE_HM, MODE_CSP, MODE_CSV
  } dsoc_mode_e;

  typedef struct packed {
    logic shutdown;
    logic switch_on;
    logic enable_op;
    logic disable_op;
    logic disable_voltage;
    logic quick_stop;
  } dsoc_cmd_s;

  typedef struct packed {
    logic fault_in;
    logic info_active;
    logic init_done;
    logic int_limit;
    logic voltage_on;
    logic motor_stopped;
    logic ext_stop_active;
  } dsoc_env_s;

  typedef struct packed {
    logic current_off;
    logic deexcite;
    dsoc_decel_e decel;
  } dsoc_stop_s;

endpackage

// >>> dsoc_opt_reg.sv
// One validated option object with its own index and accepted value set
`timescale 1ns/10ps
module dsoc_opt_reg #(
  parameter int W = 16,
  parameter logic [15:0] IDX = 16'h0000,
  parameter logic [W-1:0] RST = '0,
  parameter logic [15:0] ACC = 16'h0001
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [15:0] index,
  input wire logic [15:0] wdata,
  output logic [W-1:0] value_r,
  output logic hit,
  output logic ok
);
  // Negative values fail the upper-bits test, so the signed range needs no extra compare
  assign hit = wr_en && (index == IDX);
  assign ok = hit && (wdata[15:4] == 12'h000) && ACC[wdata[3:0]];

  always_ff @(posedge mclk) begin
    if (rst) begin
      value_r <= RST;
    end else if (ok) begin
      value_r <= wdata[W-1:0];
    end
  end
endmodule

// >>> dsoc_ctrl.sv
// Drive state, stop action selection, status word and option objects
`timescale 1ns/10ps
`include "dsoc_cfg.svh"
module dsoc_ctrl (
  input wire logic mclk,
  input wire logic rst,
  input wire dsoc_pkg::dsoc_cmd_s cmd,
  input wire dsoc_pkg::dsoc_env_s env,
  input wire logic [15:0] ctrl_word,
  input wire logic obj_wr_en,
  input wire logic obj_rd_en,
  input wire logic [15:0] obj_index,
  input wire logic [15:0] obj_wdata,
  output logic [15:0] obj_rdata_r,
  output logic obj_rd_valid_r,
  output logic obj_rd_err_r,
  output logic obj_wr_ok_r,
  output logic obj_wr_err_r,
  output logic [15:0] status_word_r,
  output dsoc_pkg::dsoc_stop_s stop_r,
  output logic [7:0] active_mode_r,
  output dsoc_pkg::dsoc_mode_e mode_kind_r,
  output logic fault_reset_r
);
  logic [15:0] qso_val;
  logic [15:0] sdo_val;
  logic [15:0] doo_val;
  logic [15:0] hlo_val;
  logic [7:0] mode_val;
  logic [4:0] hit;
  logic [4:0] ok;
  logic [15:0] qso_act_r;
  logic cw7_q_r;
  logic alarm_r;
  logic halt_stop_r;
  logic freset_rise;
  logic qs_go;
  logic shut_go;
  logic dis_go;
  logic halt_go;
  logic qs_done;
  logic enter_open;
  dsoc_pkg::dsoc_state_e state_r;
  dsoc_pkg::dsoc_state_e state_nxt;
  logic [15:0] status_nxt;

  dsoc_opt_reg #(.W(16), .IDX(`DSOC_IDX_QSO), .RST(`DSOC_RST_QSO), .ACC(`DSOC_ACC_QSO)) u_qso (
    .mclk(mclk), .rst(rst), .wr_en(obj_wr_en), .index(obj_index), .wdata(obj_wdata),
    .value_r(qso_val), .hit(hit[0]), .ok(ok[0])
  );
  dsoc_opt_reg #(.W(16), .IDX(`DSOC_IDX_SDO), .RST(`DSOC_RST_SDO), .ACC(`DSOC_ACC_SDO)) u_sdo (
    .mclk(mclk), .rst(rst), .wr_en(obj_wr_en), .index(obj_index), .wdata(obj_wdata),
    .value_r(sdo_val), .hit(hit[1]), .ok(ok[1])
  );
  dsoc_opt_reg #(.W(16), .IDX(`DSOC_IDX_DOO), .RST(`DSOC_RST_DOO), .ACC(`DSOC_ACC_DOO)) u_doo (
    .mclk(mclk), .rst(rst), .wr_en(obj_wr_en), .index(obj_index), .wdata(obj_wdata),
    .value_r(doo_val), .hit(hit[2]), .ok(ok[2])
  );
  dsoc_opt_reg #(.W(16), .IDX(`DSOC_IDX_HLO), .RST(`DSOC_RST_HLO), .ACC(`DSOC_ACC_HLO)) u_hlo (
    .mclk(mclk), .rst(rst), .wr_en(obj_wr_en), .index(obj_index), .wdata(obj_wdata),
    .value_r(hlo_val), .hit(hit[3]), .ok(ok[3])
  );
  dsoc_opt_reg #(.W(8), .IDX(`DSOC_IDX_MODE), .RST(`DSOC_RST_MODE), .ACC(`DSOC_ACC_MODE)) u_mode (
    .mclk(mclk), .rst(rst), .wr_en(obj_wr_en), .index(obj_index), .wdata(obj_wdata),
    .value_r(mode_val), .hit(hit[4]), .ok(ok[4])
  );

  // Events
  assign freset_rise = ctrl_word[`DSOC_CW_FRESET] && !cw7_q_r;
  assign qs_go = cmd.quick_stop && ((state_r == dsoc_pkg::DSM_OPEN) ||
                 (state_r == dsoc_pkg::DSM_STOP_SHUT) || (state_r == dsoc_pkg::DSM_STOP_DIS));
  assign shut_go = cmd.shutdown && !cmd.quick_stop && (state_r == dsoc_pkg::DSM_OPEN);
  assign dis_go = cmd.disable_op && !cmd.quick_stop && !cmd.shutdown &&
                  (state_r == dsoc_pkg::DSM_OPEN);
  assign halt_go = ctrl_word[`DSOC_CW_HALT] && (state_r == dsoc_pkg::DSM_OPEN) &&
                   !cmd.quick_stop && !cmd.shutdown && !cmd.disable_op;
  // Quick stop reaches its end once the motor stands; option 0 cuts current at once
  assign qs_done = (state_r == dsoc_pkg::DSM_QSA) &&
                   (env.motor_stopped || (qso_act_r == 16'h0000));
  assign enter_open = (state_nxt == dsoc_pkg::DSM_OPEN) && (state_r != dsoc_pkg::DSM_OPEN);

  always_ff @(posedge mclk) begin
    if (rst) begin
      cw7_q_r <= 1'b0;
    end else begin
      cw7_q_r <= ctrl_word[`DSOC_CW_FRESET];
    end
  end

  // Alarm latch: a new fault in the reset cycle keeps the alarm
  always_ff @(posedge mclk) begin
    if (rst) begin
      alarm_r <= 1'b0;
    end else if (env.fault_in) begin
      alarm_r <= 1'b1;
    end else if (freset_rise) begin
      alarm_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      fault_reset_r <= 1'b0;
    end else begin
      fault_reset_r <= freset_rise && alarm_r && !env.fault_in;
    end
  end

  // Option in force for a running quick stop is frozen at its start
  // A value written during the stop waits for the next one, so standstill keeps its end state
  always_ff @(posedge mclk) begin
    if (rst) begin
      qso_act_r <= `DSOC_RST_QSO;
    end else if (state_r != dsoc_pkg::DSM_QSA) begin
      // Taken only outside the stop: re-reading at standstill would leave a kept stop state
      qso_act_r <= qso_val;
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      dsoc_pkg::DSM_SOD: begin
        if (cmd.shutdown) begin
          state_nxt = dsoc_pkg::DSM_READY;
        end
      end
      dsoc_pkg::DSM_READY: begin
        if (cmd.disable_voltage || cmd.quick_stop) begin
          state_nxt = dsoc_pkg::DSM_SOD;
        end else if (cmd.switch_on) begin
          state_nxt = dsoc_pkg::DSM_SWON;
        end
      end
      dsoc_pkg::DSM_SWON: begin
        if (cmd.disable_voltage || cmd.quick_stop) begin
          state_nxt = dsoc_pkg::DSM_SOD;
        end else if (cmd.shutdown) begin
          state_nxt = dsoc_pkg::DSM_READY;
        end else if (cmd.enable_op) begin
          state_nxt = dsoc_pkg::DSM_OPEN;
        end
      end
      dsoc_pkg::DSM_OPEN: begin
        if (qs_go) begin
          state_nxt = dsoc_pkg::DSM_QSA;
        end else if (shut_go) begin
          state_nxt = (sdo_val == 16'h0000) ? dsoc_pkg::DSM_READY : dsoc_pkg::DSM_STOP_SHUT;
        end else if (dis_go) begin
          state_nxt = (doo_val == 16'h0000) ? dsoc_pkg::DSM_SWON : dsoc_pkg::DSM_STOP_DIS;
        end else if (cmd.disable_voltage) begin
          state_nxt = dsoc_pkg::DSM_SOD;
        end
      end
      dsoc_pkg::DSM_STOP_SHUT: begin
        if (qs_go) begin
          state_nxt = dsoc_pkg::DSM_QSA;
        end else if (env.motor_stopped) begin
          state_nxt = dsoc_pkg::DSM_READY;
        end
      end
      dsoc_pkg::DSM_STOP_DIS: begin
        if (qs_go) begin
          state_nxt = dsoc_pkg::DSM_QSA;
        end else if (env.motor_stopped) begin
          state_nxt = dsoc_pkg::DSM_SWON;
        end
      end
      dsoc_pkg::DSM_QSA: begin
        if (cmd.disable_voltage) begin
          state_nxt = dsoc_pkg::DSM_SOD;
        end else if (qs_done && !qso_act_r[2]) begin
          state_nxt = dsoc_pkg::DSM_SOD;
        end else if (qs_done && cmd.enable_op) begin
          state_nxt = dsoc_pkg::DSM_OPEN;
        end
      end
      dsoc_pkg::DSM_FAULT: begin
        if (freset_rise && !env.fault_in) begin
          state_nxt = dsoc_pkg::DSM_SOD;
        end
      end
      default: begin
        state_nxt = dsoc_pkg::DSM_SOD;
      end
    endcase
    if (env.fault_in) begin
      state_nxt = dsoc_pkg::DSM_FAULT;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r <= dsoc_pkg::DSM_SOD;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Halt owns the deceleration only while it started it
  always_ff @(posedge mclk) begin
    if (rst) begin
      halt_stop_r <= 1'b0;
    end else if (!halt_go) begin
      halt_stop_r <= 1'b0;
    end else if (stop_r.decel == dsoc_pkg::DEC_NONE) begin
      halt_stop_r <= 1'b1;
    end
  end

  // Stop action toward the motion generator
  always_ff @(posedge mclk) begin
    if (rst) begin
      stop_r <= '0;
    end else if (env.fault_in) begin
      stop_r.current_off <= 1'b1;
      stop_r.deexcite <= 1'b0;
      stop_r.decel <= dsoc_pkg::DEC_NONE;
    end else if (enter_open) begin
      stop_r <= '0;
    end else if (qs_go) begin
      if (qso_val == 16'h0000) begin
        stop_r.current_off <= 1'b1;
        stop_r.decel <= dsoc_pkg::DEC_NONE;
      end else if (env.ext_stop_active) begin
        stop_r.decel <= stop_r.decel;
      end else if (stop_r.decel != dsoc_pkg::DEC_NONE) begin
        stop_r.decel <= dsoc_pkg::DEC_QUICK;
      end else begin
        case (qso_val[1:0])
          2'h1: stop_r.decel <= dsoc_pkg::DEC_PROFILE;
          2'h2: stop_r.decel <= dsoc_pkg::DEC_QUICK;
          default: stop_r.decel <= dsoc_pkg::DEC_IMMED;
        endcase
      end
    end else if (shut_go || dis_go) begin
      if ((shut_go ? sdo_val : doo_val) == 16'h0000) begin
        stop_r.current_off <= 1'b1;
      end else begin
        stop_r.decel <= dsoc_pkg::DEC_PROFILE;
      end
    end else if (((state_r == dsoc_pkg::DSM_STOP_SHUT) || (state_r == dsoc_pkg::DSM_STOP_DIS))
                 && env.motor_stopped) begin
      stop_r.deexcite <= 1'b1;
      stop_r.decel <= dsoc_pkg::DEC_NONE;
    end else if (qs_done) begin
      stop_r.decel <= dsoc_pkg::DEC_NONE;
      stop_r.current_off <= !qso_act_r[2] || (qso_act_r == 16'h0000);
    end else if (halt_go && (stop_r.decel == dsoc_pkg::DEC_NONE)) begin
      case (hlo_val[1:0])
        2'h2: stop_r.decel <= dsoc_pkg::DEC_QUICK;
        2'h3: stop_r.decel <= dsoc_pkg::DEC_IMMED;
        default: stop_r.decel <= dsoc_pkg::DEC_PROFILE;
      endcase
    end else if (halt_stop_r && !halt_go) begin
      stop_r.decel <= dsoc_pkg::DEC_NONE;
    end
  end

  // Mode change waits for standstill so a running profile is never switched mid-move
  always_ff @(posedge mclk) begin
    if (rst) begin
      active_mode_r <= `DSOC_RST_MODE;
    end else if (env.motor_stopped) begin
      active_mode_r <= mode_val;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      mode_kind_r <= dsoc_pkg::MODE_NONE;
    end else if (env.motor_stopped) begin
      case (mode_val)
        `DSOC_MODE_PP: mode_kind_r <= dsoc_pkg::MODE_PP;
        `DSOC_MODE_PV: mode_kind_r <= dsoc_pkg::MODE_PV;
        `DSOC_MODE_HM: mode_kind_r <= dsoc_pkg::MODE_HM;
        `DSOC_MODE_CSP: mode_kind_r <= dsoc_pkg::MODE_CSP;
        `DSOC_MODE_CSV: mode_kind_r <= dsoc_pkg::MODE_CSV;
        default: mode_kind_r <= dsoc_pkg::MODE_NONE;
      endcase
    end
  end

  always_comb begin
    status_nxt = 16'h0000;
    case (state_nxt)
      dsoc_pkg::DSM_SOD: status_nxt[`DSOC_SW_SOD] = 1'b1;
      dsoc_pkg::DSM_READY: begin
        status_nxt[`DSOC_SW_RTSO] = 1'b1;
        status_nxt[`DSOC_SW_QS] = 1'b1;
      end
      dsoc_pkg::DSM_SWON: begin
        status_nxt[`DSOC_SW_RTSO] = 1'b1;
        status_nxt[`DSOC_SW_SO] = 1'b1;
        status_nxt[`DSOC_SW_QS] = 1'b1;
      end
      dsoc_pkg::DSM_QSA: begin
        status_nxt[`DSOC_SW_RTSO] = 1'b1;
        status_nxt[`DSOC_SW_SO] = 1'b1;
        status_nxt[`DSOC_SW_OE] = 1'b1;
      end
      dsoc_pkg::DSM_FAULT: status_nxt[`DSOC_SW_FAULT] = 1'b1;
      default: begin
        status_nxt[`DSOC_SW_RTSO] = 1'b1;
        status_nxt[`DSOC_SW_SO] = 1'b1;
        status_nxt[`DSOC_SW_OE] = 1'b1;
        status_nxt[`DSOC_SW_QS] = 1'b1;
      end
    endcase
    status_nxt[`DSOC_SW_VOLT] = env.voltage_on;
    status_nxt[`DSOC_SW_INFO] = env.info_active;
    status_nxt[`DSOC_SW_REMOTE] = env.init_done;
    status_nxt[`DSOC_SW_ILIM] = env.int_limit;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      status_word_r <= 16'h0000;
    end else begin
      status_word_r <= status_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      obj_wr_ok_r <= 1'b0;
      obj_wr_err_r <= 1'b0;
    end else begin
      obj_wr_ok_r <= |ok;
      obj_wr_err_r <= obj_wr_en && !(|ok);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      obj_rdata_r <= 16'h0000;
      obj_rd_valid_r <= 1'b0;
      obj_rd_err_r <= 1'b0;
    end else begin
      obj_rd_valid_r <= obj_rd_en;
      obj_rd_err_r <= 1'b0;
      obj_rdata_r <= 16'h0000;
      if (!obj_rd_en) begin
        obj_rdata_r <= 16'h0000;
      end else if (obj_index == `DSOC_IDX_QSO) begin
        obj_rdata_r <= qso_val;
      end else if (obj_index == `DSOC_IDX_SDO) begin
        obj_rdata_r <= sdo_val;
      end else if (obj_index == `DSOC_IDX_DOO) begin
        obj_rdata_r <= doo_val;
      end else if (obj_index == `DSOC_IDX_HLO) begin
        obj_rdata_r <= hlo_val;
      end else if (obj_index == `DSOC_IDX_MODE) begin
        obj_rdata_r <= {{8{mode_val[7]}}, mode_val};
      end else if (obj_index == `DSOC_IDX_MODE_DISP) begin
        obj_rdata_r <= {{8{active_mode_r[7]}}, active_mode_r};
      end else if (obj_index == `DSOC_IDX_STATUS) begin
        obj_rdata_r <= status_word_r;
      end else begin
        obj_rd_err_r <= 1'b1;
      end
    end
  end
endmodule

// >>> dsoc_monitor.sv
// Port checker of the stop option control
`timescale 1ns/10ps
`include "dsoc_cfg.svh"
module dsoc_monitor (
  input wire logic mclk,
  input wire logic rst,
  input wire dsoc_pkg::dsoc_cmd_s cmd,
  input wire dsoc_pkg::dsoc_env_s env,
  input wire logic [15:0] ctrl_word,
  input wire logic obj_wr_en,
  input wire logic obj_rd_en,
  input wire logic [15:0] obj_index,
  input wire logic [15:0] obj_wdata,
  input wire logic [15:0] obj_rdata_r,
  input wire logic obj_rd_valid_r,
  input wire logic obj_rd_err_r,
  input wire logic obj_wr_ok_r,
  input wire logic obj_wr_err_r,
  input wire logic [15:0] status_word_r,
  input wire dsoc_pkg::dsoc_stop_s stop_r,
  input wire logic [7:0] active_mode_r,
  input wire logic fault_reset_r
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  chk_wr_answer: assert property (
    obj_wr_en |=> obj_wr_ok_r != obj_wr_err_r) else $error("write answer missing");
  chk_qso_refuse: assert property (
    obj_wr_en && obj_index == `DSOC_IDX_QSO && (obj_wdata > 16'h0007 || obj_wdata == 16'h0004)
    |=> obj_wr_err_r) else $error("bad stop option taken");
  chk_mode_refuse: assert property (
    obj_wr_en && obj_index == `DSOC_IDX_MODE && obj_wdata[15:8] != 8'h00
    |=> obj_wr_err_r) else $error("bad mode taken");
  chk_qso_read: assert property (
    obj_rd_en && obj_index == `DSOC_IDX_QSO |=> obj_rd_valid_r && !obj_rd_err_r
    && obj_rdata_r[15:3] == 13'h0000 && obj_rdata_r[2:0] != 3'h4) else $error("stop option read");
  // Env bits are copied with one cycle of latency, never before reset has gone
  chk_status_env: assert property (
    !$past(rst) |-> {status_word_r[11], status_word_r[9], status_word_r[7], status_word_r[4]}
    == {$past(env.int_limit), $past(env.init_done), $past(env.info_active), $past(env.voltage_on)})
    else $error("status env bits");
  chk_fault_status: assert property (
    env.fault_in |=> status_word_r[3]) else $error("fault not shown");
  chk_fault_reset: assert property (
    fault_reset_r |-> $past(ctrl_word[7]) && !$past(ctrl_word[7], 2)) else $error("reset edge");
  chk_halt_decel: assert property (
    ctrl_word[8] && status_word_r[6:0] == 7'h27 && stop_r == '0 && cmd == '0 && !env.fault_in
    && !env.ext_stop_active |=> stop_r.decel != dsoc_pkg::DEC_NONE) else $error("halt ignored");
  chk_mode_defer: assert property (
    !$past(rst) && !$stable(active_mode_r) |-> $past(env.motor_stopped)) else $error("mode moved");
  cov_halt: cover property (ctrl_word[8] && stop_r.decel == dsoc_pkg::DEC_QUICK);
  cov_qsa: cover property (status_word_r[6:0] == 7'h07);
  cov_fault_reset: cover property (fault_reset_r);
endmodule
bind dsoc_ctrl dsoc_monitor i_mon (.mclk(mclk), .rst(rst), .cmd(cmd), .env(env),
  .ctrl_word(ctrl_word), .obj_wr_en(obj_wr_en), .obj_rd_en(obj_rd_en), .obj_index(obj_index),
  .obj_wdata(obj_wdata), .obj_rdata_r(obj_rdata_r), .obj_rd_valid_r(obj_rd_valid_r),
  .obj_rd_err_r(obj_rd_err_r), .obj_wr_ok_r(obj_wr_ok_r), .obj_wr_err_r(obj_wr_err_r),
  .status_word_r(status_word_r), .stop_r(stop_r), .active_mode_r(active_mode_r),
  .fault_reset_r(fault_reset_r));

// >>> dsoc_master.sv
// Fieldbus master model that writes and reads drive objects
`timescale 1ns/10ps
module dsoc_master (
  input wire logic mclk,
  output logic obj_wr_en,
  output logic obj_rd_en,
  output logic [15:0] obj_index,
  output logic [15:0] obj_wdata,
  input wire logic [15:0] obj_rdata_r,
  input wire logic obj_rd_valid_r,
  input wire logic obj_rd_err_r,
  input wire logic obj_wr_ok_r,
  input wire logic obj_wr_err_r
);
  initial begin
    obj_wr_en = 1'b0;
    obj_rd_en = 1'b0;
    obj_index = 16'h0000;
    obj_wdata = 16'h0000;
  end
  task automatic access(input logic wr, input logic [15:0] a, input logic [15:0] val,
      output logic ok, output logic err, output logic [15:0] d);
    @(negedge mclk);
    obj_wr_en = wr;
    obj_rd_en = !wr;
    obj_index = a;
    obj_wdata = val;
    @(negedge mclk);
    ok = wr ? obj_wr_ok_r : obj_rd_valid_r;
    err = wr ? obj_wr_err_r : obj_rd_err_r;
    d = obj_rdata_r;
    obj_wr_en = 1'b0;
    obj_rd_en = 1'b0;
    // Released lines flip so a stale word cannot pass for a live one
    obj_index = ~a;
    obj_wdata = ~val;
  endtask
endmodule

// >>> dsoc_ctrl_bench.sv
// Self-checking bench of the stop option control
`timescale 1ns/10ps
`include "dsoc_cfg.svh"
module dsoc_ctrl_bench;
  localparam logic [5:0] C_SD = 6'h20;
  localparam logic [5:0] C_SO = 6'h10;
  localparam logic [5:0] C_EO = 6'h08;
  localparam logic [5:0] C_DO = 6'h04;
  localparam logic [5:0] C_DV = 6'h02;
  localparam logic [5:0] C_QS = 6'h01;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  dsoc_pkg::dsoc_cmd_s cmd = '0;
  dsoc_pkg::dsoc_env_s env = '0;
  logic [15:0] ctrl_word = 16'h0000;
  logic wr_en, rd_en, rd_valid, rd_err, wr_ok, wr_err, fault_rst;
  logic [15:0] idx, wdata, rdata, status, v;
  dsoc_pkg::dsoc_stop_s stop;
  logic [7:0] amode;
  dsoc_pkg::dsoc_mode_e mkind;
  logic [31:0] lfsr = 32'hf0cb658d;
  logic [15:0] oidx [5] = '{`DSOC_IDX_QSO, `DSOC_IDX_SDO, `DSOC_IDX_DOO, `DSOC_IDX_HLO,
    `DSOC_IDX_MODE};
  logic [15:0] msk [5] = '{16'h00ef, 16'h0003, 16'h0003, 16'h000e, 16'h034b};
  logic [7:0] modes [6] = '{8'h00, 8'h01, 8'h03, 8'h06, 8'h08, 8'h09};
  int opt [5] = '{2, 1, 1, 1, 0};
  int failures = 0;
  int n_checks = 0;
  int cycles = 0;

  dsoc_ctrl i_dut (.mclk(mclk), .rst(rst), .cmd(cmd), .env(env), .ctrl_word(ctrl_word),
    .obj_wr_en(wr_en), .obj_rd_en(rd_en), .obj_index(idx), .obj_wdata(wdata),
    .obj_rdata_r(rdata), .obj_rd_valid_r(rd_valid), .obj_rd_err_r(rd_err),
    .obj_wr_ok_r(wr_ok), .obj_wr_err_r(wr_err), .status_word_r(status), .stop_r(stop),
    .active_mode_r(amode), .mode_kind_r(mkind), .fault_reset_r(fault_rst));
  dsoc_master i_mst (.mclk(mclk), .obj_wr_en(wr_en), .obj_rd_en(rd_en), .obj_index(idx),
    .obj_wdata(wdata), .obj_rdata_r(rdata), .obj_rd_valid_r(rd_valid),
    .obj_rd_err_r(rd_err), .obj_wr_ok_r(wr_ok), .obj_wr_err_r(wr_err));

  initial begin
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    if (failures == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic good(input int k, input logic [15:0] x);
    return x < 16'h0010 && msk[k][x[3:0]];
  endfunction
  function automatic logic [15:0] sw(input logic [15:0] base);
    return base | {4'h0, env.int_limit, 1'b0, env.init_done, 1'b0, env.info_active, 2'b00,
      env.voltage_on, 4'h0};
  endfunction
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] x, input logic ok_exp);
    logic ok, err;
    logic [15:0] d;
    i_mst.access(1'b1, a, x, ok, err, d);
    cmp("wr_ok", 16'(ok_exp), 16'(ok));
    cmp("wr_err", 16'(!ok_exp), 16'(err));
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] exp, input logic bad);
    logic ok, err;
    logic [15:0] d;
    i_mst.access(1'b0, a, 16'h0000, ok, err, d);
    cmp("rd_valid", 16'h0001, 16'(ok));
    cmp("rd_err", 16'(bad), 16'(err));
    cmp("rd_data", exp, d);
  endtask
  // Commands are one-cycle pulses; a held level would act again on every edge
  task automatic pulse(input logic [5:0] c);
    @(negedge mclk);
    cmd = c;
    wt(1);
    cmd = '0;
    wt(1);
  endtask
  task automatic go_open();
    pulse(C_SD);
    pulse(C_SO);
    pulse(C_EO);
    cmp("status", sw(16'h0027), status);
  endtask

  initial begin
    wt(5);
    rst = 1'b0;
    wt(1);
    cmp("status", 16'h0040, status);
    rd(`DSOC_IDX_STATUS, 16'h0040, 1'b0);
    for (int k = 0; k < 5; k++) rd(oidx[k], 16'(opt[k]), 1'b0);
    for (int i = 0; i < 4; i++) begin
      lfsr = nxt(lfsr);
      env = lfsr[6:0] & 7'h3e;
      wt(2);
      cmp("status", sw(16'h0040), status);
    end
    for (int k = 0; k < 5; k++) begin
      for (int i = 0; i < 12; i++) begin
        lfsr = nxt(lfsr);
        v = (i == 11) ? {12'h000, lfsr[3:0]} : 16'(i - 1);
        wr(oidx[k], v, good(k, v));
        if (good(k, v)) opt[k] = int'(v);
        rd(oidx[k], 16'(opt[k]), 1'b0);
      end
    end
    wr(16'h1234, 16'h0000, 1'b0);
    rd(16'h1234, 16'h0000, 1'b1);
    env = 7'h16;
    for (int i = 0; i < 6; i++) begin
      wr(`DSOC_IDX_MODE, 16'(modes[i]), 1'b1);
      wt(1);
      cmp("mode", 16'(modes[i]), 16'(amode));
      cmp("kind", 16'(i), 16'(mkind));
    end
    env.motor_stopped = 1'b0;
    wr(`DSOC_IDX_MODE, 16'h0001, 1'b1);
    wt(3);
    cmp("mode", 16'h0009, 16'(amode));
    env.motor_stopped = 1'b1;
    wt(2);
    cmp("mode", 16'h0001, 16'(amode));
    rd(`DSOC_IDX_MODE_DISP, 16'h0001, 1'b0);
    for (int o = 0; o < 8; o++) begin
      if (o == 4) continue;
      env = 7'h14;
      wr(`DSOC_IDX_QSO, 16'(o), 1'b1);
      go_open();
      pulse(C_QS);
      cmp("stop", {12'h000, o == 0, 1'b0, 2'(o)}, 16'(stop));
      cmp("status", sw(o == 0 ? 16'h0040 : 16'h0007), status);
      if (o > 0) begin
        wr(`DSOC_IDX_QSO, 16'(o ^ 4), 1'b1);
        env.motor_stopped = 1'b1;
        wt(2);
        cmp("status", sw(o < 4 ? 16'h0040 : 16'h0007), status);
        pulse(C_DV);
      end
    end
    env = 7'h14;
    go_open();
    for (int h = 1; h < 4; h++) begin
      wr(`DSOC_IDX_HLO, 16'(h), 1'b1);
      ctrl_word[8] = 1'b1;
      wt(2);
      cmp("stop", 16'(h), 16'(stop));
      cmp("status", sw(16'h0027), status);
      ctrl_word[8] = 1'b0;
      wt(2);
      cmp("stop", 16'h0000, 16'(stop));
    end
    ctrl_word[8] = 1'b1;
    wt(2);
    pulse(C_QS);
    cmp("stop", 16'h0002, 16'(stop));
    pulse(C_DV);
    go_open();
    env.ext_stop_active = 1'b1;
    pulse(C_QS);
    cmp("stop", 16'h0003, 16'(stop));
    ctrl_word[8] = 1'b0;
    pulse(C_DV);
    for (int s = 0; s < 4; s++) begin
      env = 7'h14;
      wr(s < 2 ? `DSOC_IDX_SDO : `DSOC_IDX_DOO, 16'(s % 2), 1'b1);
      go_open();
      pulse(s < 2 ? C_SD : C_DO);
      v = s < 2 ? 16'h0021 : 16'h0023;
      if (s % 2 == 0) begin
        cmp("status", sw(v), status);
        cmp("stop", 16'h0008, 16'(stop));
      end else begin
        cmp("stop", 16'h0001, 16'(stop));
        env.motor_stopped = 1'b1;
        wt(2);
        cmp("status", sw(v), status);
        cmp("stop", 16'h0004, 16'(stop));
      end
      pulse(C_DV);
    end
    env.fault_in = 1'b1;
    wt(2);
    cmp("status", sw(16'h0008), status);
    ctrl_word[7] = 1'b1;
    wt(2);
    env.fault_in = 1'b0;
    wt(2);
    cmp("status", sw(16'h0008), status);
    ctrl_word[7] = 1'b0;
    wt(1);
    ctrl_word[7] = 1'b1;
    wt(1);
    cmp("fault_reset", 16'h0001, 16'(fault_rst));
    wt(1);
    cmp("status", sw(16'h0040), status);
    end_of_test();
  end
endmodule
